/* File: hw/mct_defines.svh */
// offsets including identity addresses, field positions, reset values and fault code
// Notes on behaviour
// - high byte read copies low byte to shadow
// - low byte read returns the shadow copy
// - repeated high byte read refreshes shadow
// - eleven bits: integer byte, three fraction bits
// - two's complement, -128 to 127.875 degrees
// - diode fault reads as code 80_00
// - status at 02h, read-only, flags reset zero, busy bit live
// - limit flags clear on channel status read
// - converting flag never raises the interrupt
// - hottest change flag, cleared by status read
// - high flag on temp >= high limit
// - low flag on temp < low limit
// - fault flag on any external diode fault
// - critical flag on temp >= critical limit
// - shutdown flag and pin from channel one
// - status read clears shutdown flag once released
// - high limits reset 55h, low and fraction limits zero, writable
// - critical limits channels three to seven, 55h
// - beta settings four and six reset 08h
// - fixed read-only identity bytes at top
// - unmasked interrupt follows alerting flags
`ifndef MCT_DEFINES_SVH
`define MCT_DEFINES_SVH

`define MCT_STATUS_ADDR     8'h02
`define MCT_PRODUCT_ADDR    8'hfd
`define MCT_MAKER_ADDR      8'hfe
`define MCT_REVISION_ADDR   8'hff
`define MCT_BETA4_ADDR      8'h71
`define MCT_BETA6_ADDR      8'h72

// channel order: internal, ext1 .. ext7
`define MCT_TINT_ADDRS  '{8'h00, 8'h01, 8'h23, 8'h2a, 8'h41, 8'h43, 8'h45, 8'h47}
`define MCT_TFRAC_ADDRS '{8'h29, 8'h10, 8'h24, 8'h2b, 8'h42, 8'h44, 8'h46, 8'h48}
`define MCT_HINT_ADDRS  '{8'h05, 8'h07, 8'h15, 8'h2c, 8'h50, 8'h54, 8'h58, 8'h5c}
`define MCT_LINT_ADDRS  '{8'h06, 8'h08, 8'h16, 8'h2d, 8'h51, 8'h55, 8'h59, 8'h5d}
`define MCT_HFRAC_ADDRS '{8'h00, 8'h13, 8'h17, 8'h2e, 8'h52, 8'h56, 8'h5a, 8'h5e}
`define MCT_LFRAC_ADDRS '{8'h00, 8'h14, 8'h18, 8'h2f, 8'h53, 8'h57, 8'h5b, 8'h5f}
`define MCT_CRIT_ADDRS  '{8'h00, 8'h00, 8'h00, 8'h30, 8'h64, 8'h65, 8'h66, 8'h67}

`define MCT_HIGH_LIMIT_RESET 8'h55
`define MCT_LOW_LIMIT_RESET  8'h00
`define MCT_FRAC_RESET       8'h00
`define MCT_CRIT_RESET       8'h55
`define MCT_BETA_RESET       8'h08
`define MCT_FAULT_CODE       11'h400

`define MCT_ST_BUSY   7
`define MCT_ST_HOT    6
`define MCT_ST_HIGH   4
`define MCT_ST_LOW    3
`define MCT_ST_FAULT  2
`define MCT_ST_CRIT   1
`define MCT_ST_HW_SHUTDOWN_FLAG   0

`endif

/* File: hw/mct_pkg.sv */
// types shared by the temperature register bank
package mct_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mct_req_type;

  typedef struct packed {
    logic        valid;
    logic [2:0]  chan;
    logic        fault;
    logic [10:0] temp;
  } mct_result_type;

  typedef struct packed {
    logic high;
    logic low;
    logic crit;
    logic fault;
  } mct_clear_type;

endpackage : mct_pkg

/* File: hw/mct_regbank.sv */
// register bank of the multi-channel temperature monitor
`timescale 1ns/1ps
`default_nettype none
`include "mct_defines.svh"

module mct_regbank #(
  parameter logic [7:0] PRODUCT_CODE  = 8'ha5,  // arbitrary value
  parameter logic [7:0] MAKER_CODE    = 8'h3c,  // arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h07   // arbitrary value
) (
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire mct_pkg::mct_req_type    req,
  output logic [7:0]              rdata,
  input  wire mct_pkg::mct_result_type result,
  input  wire mct_pkg::mct_clear_type  clear,
  input  wire logic               converting,
  input  wire logic               leader_tracking_enable,
  input  wire logic [2:0]         hottest_chan,
  input  wire logic [7:0]         hw_shutdown_limit,
  input  wire logic               interrupt_mask,
  output logic                    alert_n,
  output logic                    shutdown_output_pin,
  output logic [7:0]              general_status
);

  localparam int NCH = 8;
  localparam logic [7:0] TINT  [NCH] = `MCT_TINT_ADDRS;
  localparam logic [7:0] TFRAC [NCH] = `MCT_TFRAC_ADDRS;
  localparam logic [7:0] HINT  [NCH] = `MCT_HINT_ADDRS;
  localparam logic [7:0] LINT  [NCH] = `MCT_LINT_ADDRS;
  localparam logic [7:0] HFRAC [NCH] = `MCT_HFRAC_ADDRS;
  localparam logic [7:0] LFRAC [NCH] = `MCT_LFRAC_ADDRS;
  localparam logic [7:0] CRIT  [NCH] = `MCT_CRIT_ADDRS;

  logic [7:0]  temp_int     [NCH];
  logic [2:0]  temp_frac    [NCH];
  logic [2:0]  shadow_frac  [NCH];
  logic [7:0]  hi_int       [NCH];
  logic [7:0]  lo_int       [NCH];
  logic [2:0]  hi_frac      [NCH];
  logic [2:0]  lo_frac      [NCH];
  logic [7:0]  crit_lim     [NCH];
  logic [7:0]  beta4;
  logic [7:0]  beta6;
  logic        flag_hot;
  logic        flag_high;
  logic        flag_low;
  logic        flag_fault;
  logic        flag_crit;
  logic        flag_hw_shutdown_flag;
  logic [2:0]  prev_hottest;
  logic [7:0]  next_rdata;
  logic        status_rd;
  logic        ev_high;
  logic        ev_low;
  logic        ev_crit;
  logic        ev_fault;
  logic        ev_hw_shutdown_flag_hot;
  logic        ev_hot;
  logic [10:0] stored_temp;
  logic        alert_term;

  assign status_rd = req.rd && (req.addr == `MCT_STATUS_ADDR);

  // diode fault replaces the reading with the reserved code
  assign stored_temp = result.fault ? `MCT_FAULT_CODE : result.temp;

  // limit checks run on each fresh non-fault result, signed eleven-bit compare
  always_comb begin
    logic signed [10:0] t;
    logic [2:0]         c;
    t           = $signed(result.temp);
    c           = result.chan;
    ev_high     = 1'b0;
    ev_low      = 1'b0;
    ev_crit     = 1'b0;
    ev_fault    = 1'b0;
    ev_hw_shutdown_flag_hot = 1'b0;
    if (result.valid) begin
      if (result.fault && (c != 3'h0)) begin
        ev_fault = 1'b1;
      end else if (!result.fault) begin
        ev_high = t >= $signed({hi_int[c], hi_frac[c]});
        ev_low  = t <  $signed({lo_int[c], lo_frac[c]});
        if (c >= 3'h3) begin
          ev_crit = t >= $signed({crit_lim[c], 3'h0});
        end
        if (c == 3'h1) begin
          ev_hw_shutdown_flag_hot = t >= $signed({hw_shutdown_limit, 3'h0});
        end
      end
    end
  end

  assign ev_hot = leader_tracking_enable && (hottest_chan != prev_hottest);

  // temperature results, integer and three left-justified fraction bits
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        temp_int[i] <= 8'h00;
      end
    end else if (result.valid) begin
      temp_int[result.chan] <= stored_temp[10:3];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        temp_frac[i] <= 3'h0;
      end
    end else if (result.valid) begin
      temp_frac[result.chan] <= stored_temp[2:0];
    end
  end

  // shadow copy taken on every high byte read, stale or not
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        shadow_frac[i] <= 3'h0;
      end
    end else if (req.rd) begin
      for (int i = 0; i < NCH; i++) begin
        if (req.addr == TINT[i]) begin
          shadow_frac[i] <= temp_frac[i];
        end
      end
    end
  end

  // writable limits; data, status and identity have no write path
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        hi_int[i] <= `MCT_HIGH_LIMIT_RESET;
      end
    end else if (req.wr) begin
      for (int i = 0; i < NCH; i++) begin
        if (req.addr == HINT[i]) begin
          hi_int[i] <= req.wdata;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        lo_int[i] <= `MCT_LOW_LIMIT_RESET;
      end
    end else if (req.wr) begin
      for (int i = 0; i < NCH; i++) begin
        if (req.addr == LINT[i]) begin
          lo_int[i] <= req.wdata;
        end
      end
    end
  end

  // internal channel has no fraction limits, so index 0 never writes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        hi_frac[i] <= 3'h0;
      end
    end else if (req.wr) begin
      for (int i = 1; i < NCH; i++) begin
        if (req.addr == HFRAC[i]) begin
          hi_frac[i] <= req.wdata[7:5];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        lo_frac[i] <= 3'h0;
      end
    end else if (req.wr) begin
      for (int i = 1; i < NCH; i++) begin
        if (req.addr == LFRAC[i]) begin
          lo_frac[i] <= req.wdata[7:5];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        crit_lim[i] <= `MCT_CRIT_RESET;
      end
    end else if (req.wr) begin
      for (int i = 3; i < NCH; i++) begin
        if (req.addr == CRIT[i]) begin
          crit_lim[i] <= req.wdata;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      beta4 <= `MCT_BETA_RESET;
    end else if (req.wr && (req.addr == `MCT_BETA4_ADDR)) begin
      beta4 <= req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      beta6 <= `MCT_BETA_RESET;
    end else if (req.wr && (req.addr == `MCT_BETA6_ADDR)) begin
      beta6 <= req.wdata;
    end
  end

  // limit flags: a new event in the clearing cycle keeps the flag set
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag_high <= 1'b0;
    end else begin
      flag_high <= ev_high || (flag_high && !clear.high);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag_low <= 1'b0;
    end else begin
      flag_low <= ev_low || (flag_low && !clear.low);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag_crit <= 1'b0;
    end else begin
      flag_crit <= ev_crit || (flag_crit && !clear.crit);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag_fault <= 1'b0;
    end else begin
      flag_fault <= ev_fault || (flag_fault && !clear.fault);
    end
  end

  // hottest change, cleared only by a status read
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prev_hottest <= 3'h0;
    end else begin
      prev_hottest <= hottest_chan;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag_hot <= 1'b0;
    end else begin
      flag_hot <= ev_hot || (flag_hot && !status_rd);
    end
  end

  // pin follows the last channel-one verdict; flag outlives the pin
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      shutdown_output_pin <= 1'b0;
    end else if (result.valid && (result.chan == 3'h1)) begin
      shutdown_output_pin <= ev_hw_shutdown_flag_hot;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag_hw_shutdown_flag <= 1'b0;
    end else if (ev_hw_shutdown_flag_hot) begin
      flag_hw_shutdown_flag <= 1'b1;
    end else if (status_rd && !shutdown_output_pin) begin
      flag_hw_shutdown_flag <= 1'b0;
    end
  end

  // busy is a live level, never part of the alert term
  always_comb begin
    general_status = 8'h00;
    general_status[`MCT_ST_BUSY]  = converting;
    general_status[`MCT_ST_HOT]   = flag_hot;
    general_status[`MCT_ST_HIGH]  = flag_high;
    general_status[`MCT_ST_LOW]   = flag_low;
    general_status[`MCT_ST_FAULT] = flag_fault;
    general_status[`MCT_ST_CRIT]  = flag_crit;
    general_status[`MCT_ST_HW_SHUTDOWN_FLAG]  = flag_hw_shutdown_flag;
  end

  // alert drawn only from high, low and fault; registered to avoid glitches
  assign alert_term = !interrupt_mask &&
                      (flag_high || flag_low || flag_fault);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= !alert_term;
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      if (req.addr == TINT[i]) begin
        next_rdata = temp_int[i];
      end
      if (req.addr == TFRAC[i]) begin
        next_rdata = {shadow_frac[i], 5'h00};
      end
      if (req.addr == HINT[i]) begin
        next_rdata = hi_int[i];
      end
      if (req.addr == LINT[i]) begin
        next_rdata = lo_int[i];
      end
      if ((i != 0) && (req.addr == HFRAC[i])) begin
        next_rdata = {hi_frac[i], 5'h00};
      end
      if ((i != 0) && (req.addr == LFRAC[i])) begin
        next_rdata = {lo_frac[i], 5'h00};
      end
      if ((i >= 3) && (req.addr == CRIT[i])) begin
        next_rdata = crit_lim[i];
      end
    end
    case (req.addr)
      `MCT_STATUS_ADDR:   next_rdata = general_status;
      `MCT_BETA4_ADDR:    next_rdata = beta4;
      `MCT_BETA6_ADDR:    next_rdata = beta6;
      `MCT_PRODUCT_ADDR:  next_rdata = PRODUCT_CODE;
      `MCT_MAKER_ADDR:    next_rdata = MAKER_CODE;
      `MCT_REVISION_ADDR: next_rdata = REVISION_CODE;
      default:            next_rdata = next_rdata;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= next_rdata;
    end
  end

endmodule : mct_regbank
`default_nettype wire

/* File: test/mct_host.sv */
// host side model driving the register request port
`timescale 1ns/1ps
`default_nettype none

module mct_host (
  input  wire logic                 mclk,
  output var  mct_pkg::mct_req_type req,
  input  wire logic [7:0]           rdata
);
  initial req = '0;

  // released address and data show the inverse, never a stale copy
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    req <= '{1'b0, 1'b0, ~a, ~d};
    #1;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    req <= '{1'b0, 1'b0, ~a, 8'hff};
    #1;
    d = rdata;
  endtask : rd
endmodule : mct_host

`default_nettype wire

/* File: test/mct_regbank_sva.sv */
// checker for the temperature register bank ports
`timescale 1ns/1ps
`default_nettype none

module mct_regbank_sva (
  input wire logic                    mclk,
  input wire logic                    resetn,
  input wire mct_pkg::mct_req_type    req,
  input wire logic [7:0]              rdata,
  input wire mct_pkg::mct_result_type result,
  input wire mct_pkg::mct_clear_type  clear,
  input wire logic                    converting,
  input wire logic                    leader_tracking_enable,
  input wire logic [2:0]              hottest_chan,
  input wire logic [7:0]              hw_shutdown_limit,
  input wire logic                    interrupt_mask,
  input wire logic                    alert_n,
  input wire logic                    shutdown_output_pin,
  input wire logic [7:0]              general_status
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_busy_live: assert property (general_status[7] == converting)
    else $error("busy bit differs from converting");
  // alert_n is registered, so it trails the flags by one edge
  a_alert_follows: assert property (
    alert_n == !($past(|general_status[4:2]) && !$past(interrupt_mask)))
    else $error("alert_n wrong");
  a_fault_flag: assert property (result.valid && result.fault &&
    result.chan != 3'h0 |=> general_status[2]) else $error("fault lost");
  a_hw_shutdown_flag_set: assert property (result.valid && result.chan == 3'h1 &&
    !result.fault && $signed(result.temp[10:3]) >= $signed(hw_shutdown_limit)
    |=> shutdown_output_pin && general_status[0]) else $error("no shutdown");
  a_hw_shutdown_flag_hold: assert property (req.rd && req.addr == 8'h02 &&
    shutdown_output_pin && general_status[0] |=> general_status[0])
    else $error("shutdown flag cleared early");
  a_hot_clear: assert property (req.rd && req.addr == 8'h02 &&
    !(leader_tracking_enable && hottest_chan != $past(hottest_chan))
    |=> !general_status[6]) else $error("hottest flag kept");
  a_frac_zero: assert property (req.rd && req.addr inside {
    8'h29, 8'h10, 8'h24, 8'h2b, 8'h42, 8'h44, 8'h46, 8'h48}
    |=> rdata[4:0] == 5'h00)
    else $error("fraction low bits set");
  a_status_read: assert property (req.rd && req.addr == 8'h02 &&
    !result.valid |=> rdata == $past(general_status)) else $error("status");
  a_clear_high: assert property (clear.high && !result.valid |=>
    !general_status[4]) else $error("high flag not cleared");

  c_fault: cover property (result.valid && result.fault);
  c_hw_shutdown_flag: cover property ($rose(shutdown_output_pin));
  c_alert: cover property ($fell(alert_n));
endmodule : mct_regbank_sva

bind mct_regbank mct_regbank_sva chk (.mclk, .resetn, .req, .rdata, .result,
  .clear, .converting, .leader_tracking_enable, .hottest_chan,
  .hw_shutdown_limit, .interrupt_mask, .alert_n, .shutdown_output_pin,
  .general_status);

`default_nettype wire

/* File: test/test_multi_channel_temp_register_bank.sv */
// self-checking bench for the temperature register bank
`timescale 1ns/1ps
`default_nettype none

module test_multi_channel_temp_register_bank;
  logic mclk, resetn, conv, lte, mask;
  logic [2:0] hot;
  logic [7:0] shd, rdata, gs;
  logic alert_n, pin;
  mct_pkg::mct_req_type req;
  mct_pkg::mct_result_type result;
  mct_pkg::mct_clear_type clear;
  int n_mismatch, samples_checked;
  localparam logic [7:0] RA[16] = '{8'h58, 8'h59, 8'h5a, 8'h5c, 8'h5f,
    8'h64, 8'h65, 8'h66, 8'h67, 8'h71, 8'h72, 8'hfd, 8'hfe, 8'hff, 8'h02, 8'h03};
  localparam logic [7:0] RE[16] = '{8'h55, 8'h00, 8'h00, 8'h55, 8'h00,
    8'h55, 8'h55, 8'h55, 8'h55, 8'h08, 8'h08, 8'ha5, 8'h3c, 8'h07, 8'h00, 8'h00};

  mct_host host (.mclk(mclk), .req(req), .rdata(rdata));
  mct_regbank uut (.mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata),
    .result(result), .clear(clear), .converting(conv),
    .leader_tracking_enable(lte), .hottest_chan(hot),
    .hw_shutdown_limit(shd), .interrupt_mask(mask), .alert_n(alert_n),
    .shutdown_output_pin(pin), .general_status(gs));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    check(d, e);
  endtask : rc

  task res(input logic [2:0] c, input logic f, input logic [10:0] t);
    @(posedge mclk);
    result <= '{1'b1, c, f, t};
    @(posedge mclk);
    result.valid <= 1'b0;
    #1;
  endtask : res

  task clr(input logic [3:0] v);
    @(posedge mclk);
    clear <= v;
    @(posedge mclk);
    clear <= '0;
    #1;
  endtask : clr

  task t_reset;
    for (int i = 0; i < 16; i++) rc(RA[i], RE[i]);
  endtask : t_reset

  task t_write;
    host.wr(8'h5a, 8'he0);
    rc(8'h5a, 8'he0);
    host.wr(8'hfd, 8'h00);
    rc(8'hfd, 8'ha5);
    host.wr(8'h02, 8'hff);
    rc(8'h02, 8'h00);
  endtask : t_write

  // second result lands between high and low read: shadow must win
  task t_shadow;
    res(3'h4, 1'b0, 11'h0a5);
    rc(8'h41, 8'h14);
    res(3'h4, 1'b0, 11'h601);
    rc(8'h42, 8'ha0);
    rc(8'h41, 8'hc0);
    rc(8'h42, 8'h20);
    host.wr(8'h41, 8'hff);
    rc(8'h41, 8'hc0);
    check(gs, 8'h08);
    clr(4'h4);
    check(gs, 8'h00);
  endtask : t_shadow

  task t_fault;
    res(3'h5, 1'b1, 11'h123);
    rc(8'h43, 8'h80);
    rc(8'h44, 8'h00);
    check(gs, 8'h04);
    check({7'h0, alert_n}, 8'h00);
    @(posedge mclk);
    mask <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 check({7'h0, alert_n}, 8'h01);
    mask <= 1'b0;
    clr(4'h1);
    check(gs, 8'h00);
  endtask : t_fault

  task t_crit;
    res(3'h7, 1'b0, {8'h55, 3'h0});
    check(gs, 8'h12);
    clr(4'ha);
    check(gs, 8'h00);
  endtask : t_crit

  task t_hw_shutdown_flag;
    shd <= 8'h40;
    res(3'h1, 1'b0, {8'h40, 3'h0});
    check({7'h0, pin}, 8'h01);
    rc(8'h02, 8'h01);
    check(gs, 8'h01);
    res(3'h1, 1'b0, 11'h100);
    check({7'h0, pin}, 8'h00);
    rc(8'h02, 8'h01);
    check(gs, 8'h00);
  endtask : t_hw_shutdown_flag

  task t_busy;
    @(posedge mclk);
    conv <= 1'b1;
    lte <= 1'b1;
    @(posedge mclk);
    hot <= 3'h3;
    repeat (3) @(posedge mclk);
    #1 check(gs, 8'hc0);
    check({7'h0, alert_n}, 8'h01);
    rc(8'h02, 8'hc0);
    check(gs, 8'h80);
    conv <= 1'b0;
  endtask : t_busy

  task finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  initial begin
    {resetn, conv, lte, mask, hot, result, clear} = '0;
    shd = 8'h7f;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    t_reset;
    t_write;
    t_shadow;
    t_fault;
    t_crit;
    t_hw_shutdown_flag;
    t_busy;
    finish_test;
  end

  // whole run is just over a hundred cycles; this span of 4000 cycles allows ample margin
  initial begin
    #20000;
    n_mismatch++;
    finish_test;
  end
endmodule : test_multi_channel_temp_register_bank

`default_nettype wire
